// file: design/bbc_pkg.sv
// Package for the backlight boost configuration register bank
package bbc_pkg;
   // ----------------------------------------------------------------
   // Register addresses and defaults
   // ----------------------------------------------------------------
   localparam logic [7:0] BBC_ADDR_DIM_CFG   = 8'hA1;
   localparam logic [7:0] BBC_ADDR_BOOST_CFG = 8'hA2;
   localparam logic [7:0] BBC_RST_DIM_CFG    = 8'hF5;
   localparam logic [7:0] BBC_RST_BOOST_CFG  = 8'hBF;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BBC_FREQ_LSB   = 6;
   localparam int BBC_AUTO_BIT   = 5;
   localparam int BBC_THERM_LSB  = 3;
   localparam int BBC_RAMP_LSB   = 0;
   localparam int BBC_SPEED_HI   = 7;
   localparam int BBC_SPEED_LO   = 6;
   localparam int BBC_SPLIT_BIT  = 4;
   localparam int BBC_ADAPT_BIT  = 3;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int BBC_CLK_KHZ      = 25000;
   localparam logic [4:0] BBC_ADJ_DIV = 5'h10;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BBC_F156  = 2'h0,
      BBC_F312  = 2'h1,
      BBC_F625  = 2'h2,
      BBC_F1250 = 2'h3
   } bbc_freq_t;

   typedef enum logic [2:0] {
      BBC_ST_LOAD = 3'h1,
      BBC_ST_WAIT = 3'h2,
      BBC_ST_RUN  = 3'h4
   } bbc_state_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] data;
   } bbc_wr_t;

   typedef struct packed {
      bbc_freq_t   switch_rate;
      logic        auto_dim;
      logic        derate_on;
      logic [7:0]  derate_temp_c;
      logic [15:0] ramp_ms;
      logic        light_load;
      logic        split_25;
      logic        headroom_tracking_enable;
   } bbc_cfg_t;
endpackage

// file: design/bbc_regs.sv
// Backlight boost configuration registers and their decoded controls
`timescale 1ns/1ps
// Behaviour
// - Frequency field 00..11 selects 156, 312, 625, 1250 kHz boost switching.
// - Bit 5 of first register: 1 auto PWM+current dimming, 0 PWM only.
// - Thermal field 00 disables derating; 01/10/11 give 110/120/130 C.
// - Ramp code 000 applies a new brightness at once.
// - Ramp codes 001..111 give 50,75,100,150,200,300,500 ms.
// - Second register bit 7 set selects light-load adaptive boost mode.
// - Lower speed bit 0 adjusts every cycle, 1 every 16th cycle.
// - Split bit 0 selects 50 percent mode, 1 selects 25 percent.
// - Bit 3 zero uses fixed output voltage; one tracks driver headroom.
// - Written values take effect immediately, no commit needed.
// - At startup stored nonvolatile values load into the registers.
module bbc_regs
   import bbc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire bbc_wr_t    wr_i,
   input  wire logic [7:0] rd_addr_i,
   input  wire logic [7:0] nvm_dim_i,
   input  wire logic [7:0] nvm_boost_i,
   input  wire logic       nvm_valid_i,
   input  wire logic       adj_tick_i,
   output logic [7:0]      rd_data_o,
   output logic            ready_o,
   output bbc_cfg_t        cfg_o,
   output logic            boost_adjust_o
);
   // ----------------------------------------------------------------
   // Storage and load sequencing
   // ----------------------------------------------------------------
   // Index 0 holds the dimming register, index 1 the boost register
   logic [7:0] regs_q [2];
   logic [7:0] dim_d;
   logic [7:0] boost_d;
   bbc_state_t state_q;
   bbc_state_t state_d;
   logic [3:0] adj_cnt_q;
   logic [3:0] adj_cnt_d;
   bbc_cfg_t   cfg_d;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic addr_is(input logic [7:0] addr,
                                    input logic [7:0] target);
      addr_is = addr == target;
   endfunction

   // Sequencer waits only on the stored image, never on software
   function automatic bbc_state_t next_state(input bbc_state_t cur,
                                             input logic       nvm_ok);
      case (cur)
         BBC_ST_LOAD: begin
            next_state = BBC_ST_WAIT;
         end
         BBC_ST_WAIT: begin
            next_state = nvm_ok ? BBC_ST_RUN : BBC_ST_WAIT;
         end
         BBC_ST_RUN: begin
            next_state = BBC_ST_RUN;
         end
         default: begin
            next_state = BBC_ST_LOAD;
         end
      endcase
   endfunction

   function automatic logic [15:0] ramp_ms(input logic [2:0] code);
      case (code)
         3'h1:    ramp_ms = 16'h0032;
         3'h2:    ramp_ms = 16'h004B;
         3'h3:    ramp_ms = 16'h0064;
         3'h4:    ramp_ms = 16'h0096;
         3'h5:    ramp_ms = 16'h00C8;
         3'h6:    ramp_ms = 16'h012C;
         3'h7:    ramp_ms = 16'h01F4;
         default: ramp_ms = 16'h0000;
      endcase
   endfunction

   function automatic logic [7:0] derate_c(input logic [1:0] code);
      case (code)
         2'h1:    derate_c = 8'h6E;
         2'h2:    derate_c = 8'h78;
         2'h3:    derate_c = 8'h82;
         default: derate_c = 8'h00;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Write and load decode
   // ----------------------------------------------------------------
   wire logic       hit_dim   = addr_is(wr_i.addr, BBC_ADDR_DIM_CFG);
   wire logic       hit_boost = addr_is(wr_i.addr, BBC_ADDR_BOOST_CFG);
   wire logic       run       = state_q == BBC_ST_RUN;
   // Early writes are dropped: the image load would clobber them
   wire logic       wr_ok     = wr_i.we && run;
   wire logic       load_now  = state_q == BBC_ST_WAIT && nvm_valid_i;
   wire logic       wr_dim    = wr_ok && hit_dim;
   wire logic       wr_boost  = wr_ok && hit_boost;
   wire logic [7:0] dim       = regs_q[0];
   wire logic [7:0] boost     = regs_q[1];

   assign state_d = next_state(state_q, nvm_valid_i);
   assign dim_d   = load_now ? nvm_dim_i :
                    (wr_dim ? wr_i.data : dim);
   assign boost_d = load_now ? nvm_boost_i :
                    (wr_boost ? wr_i.data : boost);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= BBC_ST_LOAD;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // Defaults hold until the stored image arrives
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         regs_q[0] <= BBC_RST_DIM_CFG;
         regs_q[1] <= BBC_RST_BOOST_CFG;
      end else if (ce_i) begin
         regs_q[0] <= dim_d;
         regs_q[1] <= boost_d;
      end
   end

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   wire logic [1:0] therm     = dim[BBC_THERM_LSB +: 2];
   wire logic [2:0] ramp_code = dim[BBC_RAMP_LSB +: 3];

   // Disabled derating reads as zero degrees
   always_comb begin
      cfg_d = '0;
      cfg_d.switch_rate = bbc_freq_t'(dim[BBC_FREQ_LSB +: 2]);
      cfg_d.auto_dim = dim[BBC_AUTO_BIT];
      cfg_d.derate_on = therm != 2'h0;
      cfg_d.derate_temp_c = derate_c(therm);
      // Zero ms means step straight to the target
      cfg_d.ramp_ms = ramp_ms(ramp_code);
      cfg_d.light_load = boost[BBC_SPEED_HI];
      cfg_d.split_25 = boost[BBC_SPLIT_BIT];
      cfg_d.headroom_tracking_enable = boost[BBC_ADAPT_BIT];
   end

   // ----------------------------------------------------------------
   // Read select and adjustment pacing
   // ----------------------------------------------------------------
   // Unmapped addresses read as zero
   wire logic [7:0] rd_sel =
      addr_is(rd_addr_i, BBC_ADDR_DIM_CFG)   ? dim   :
      addr_is(rd_addr_i, BBC_ADDR_BOOST_CFG) ? boost : 8'h00;

   wire logic [3:0] adj_last   = 4'(BBC_ADJ_DIV - 5'h01);
   // Slow mode trades loop response for less ripple at light load
   wire logic       every_16th = boost[BBC_SPEED_LO];
   wire logic       cnt_full   = adj_cnt_q == adj_last;
   wire logic       adj_fire   = adj_tick_i && (!every_16th || cnt_full);

   // Free running on every tick, so the 16th-cycle phase is not reset
   assign adj_cnt_d = adj_tick_i ? adj_cnt_q + 4'h1 : adj_cnt_q;

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   // Every output comes straight from a flop to keep the pins clean
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rd_data_o <= 8'h00;
      end else if (ce_i) begin
         rd_data_o <= rd_sel;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
      end else if (ce_i) begin
         ready_o <= run;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg_o <= '0;
      end else if (ce_i) begin
         cfg_o <= cfg_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         boost_adjust_o <= 1'b0;
      end else if (ce_i) begin
         boost_adjust_o <= adj_fire;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         adj_cnt_q <= 4'h0;
      end else if (ce_i) begin
         adj_cnt_q <= adj_cnt_d;
      end
   end

endmodule

// file: verif/bbc_regs_monitor.sv
// Assertion checker for the boost configuration registers
`timescale 1ns/1ps
module bbc_regs_monitor
   import bbc_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire bbc_wr_t    wr_i,
   input wire logic [7:0] rd_addr_i,
   input wire logic [7:0] nvm_dim_i,
   input wire logic [7:0] nvm_boost_i,
   input wire logic       ready_o,
   input wire logic [7:0] rd_data_o,
   input wire bbc_cfg_t   cfg_o
);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   localparam logic [15:0] RMS [8] = '{16'h0000, 16'h0032, 16'h004B,
      16'h0064, 16'h0096, 16'h00C8, 16'h012C, 16'h01F4};
   sequence s_a1;
      ready_o && ce_i && wr_i.we && wr_i.addr == BBC_ADDR_DIM_CFG;
   endsequence
   sequence s_a2;
      ready_o && ce_i && wr_i.we && wr_i.addr == BBC_ADDR_BOOST_CFG;
   endsequence
   property p_freq;
      s_a1 |-> ##2 cfg_o.switch_rate == $past(wr_i.data[7:6], 2);
   endproperty
   a_freq: assert property (p_freq) else $error("rate wrong");
   property p_auto;
      s_a1 |-> ##2 cfg_o.auto_dim == $past(wr_i.data[5], 2);
   endproperty
   a_auto: assert property (p_auto) else $error("dim wrong");
   property p_therm;
      s_a1 |-> ##2 cfg_o.derate_on == |$past(wr_i.data[4:3], 2)
         && cfg_o.derate_temp_c == (cfg_o.derate_on ?
         8'h64 + 8'h0A * $past(wr_i.data[4:3], 2) : 8'h00);
   endproperty
   a_therm: assert property (p_therm)
      else $error("temp wrong");
   property p_ramp_off;
      s_a1 ##0 wr_i.data[2:0] == 3'h0 |-> ##2 cfg_o.ramp_ms == 16'h0000;
   endproperty
   a_ramp_off: assert property (p_ramp_off)
      else $error("ramp on");
   property p_ramp;
      s_a1 |-> ##2 cfg_o.ramp_ms == RMS[$past(wr_i.data[2:0], 2)];
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp wrong");
   property p_boost;
      s_a2 |-> ##2 {cfg_o.light_load, cfg_o.split_25,
         cfg_o.headroom_tracking_enable} ==
         {$past(wr_i.data[7], 2), $past(wr_i.data[4:3], 2)};
   endproperty
   a_boost: assert property (p_boost)
      else $error("boost wrong");
   property p_read;
      s_a1 ##1 rd_addr_i == BBC_ADDR_DIM_CFG |-> ##1
         rd_data_o == $past(wr_i.data, 2);
   endproperty
   a_read: assert property (p_read)
      else $error("readback");
   property p_load;
      $rose(ready_o) |-> cfg_o.auto_dim == $past(nvm_dim_i[5], 2)
         && cfg_o.split_25 == $past(nvm_boost_i[4], 2);
   endproperty
   a_load: assert property (p_load) else $error("load wrong");
endmodule
bind bbc_regs bbc_regs_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .wr_i(wr_i), .rd_addr_i(rd_addr_i), .nvm_dim_i(nvm_dim_i),
   .nvm_boost_i(nvm_boost_i), .ready_o(ready_o), .rd_data_o(rd_data_o),
   .cfg_o(cfg_o));

// file: verif/backlight_boost_config_regs_tb_top.sv
// Testbench for the boost configuration registers
`timescale 1ns/1ps
module backlight_boost_config_regs_tb_top;
   import bbc_pkg::*;
   typedef struct {logic [7:0] d; logic [1:0] f; logic [7:0] t;
      logic [15:0] r;} bbc_row_t;
   bbc_row_t rows [8] = '{'{8'h00, 2'h0, 8'h00, 16'h0000},
      '{8'h49, 2'h1, 8'h6E, 16'h0032}, '{8'hB2, 2'h2, 8'h78, 16'h004B},
      '{8'hDB, 2'h3, 8'h82, 16'h0064}, '{8'h2C, 2'h0, 8'h6E, 16'h0096},
      '{8'h55, 2'h1, 8'h78, 16'h00C8}, '{8'hBE, 2'h2, 8'h82, 16'h012C},
      '{8'hC7, 2'h3, 8'h00, 16'h01F4}};
   logic clk_i = 0, rst_i = 1, ce_i = 1, valid = 0, adj = 0;
   logic ready_o, boost_adjust_o;
   logic [7:0] rd_addr_i = BBC_ADDR_DIM_CFG, rd_data_o;
   bbc_wr_t wr_i = '0;
   bbc_cfg_t cfg_o;
   int failures = 0, cmp_count = 0, cyc = 0, pulses = 0;
   bbc_regs dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wr_i(wr_i),
      .rd_addr_i(rd_addr_i), .nvm_dim_i(8'h5A), .nvm_boost_i(8'h10),
      .nvm_valid_i(valid), .adj_tick_i(adj), .rd_data_o(rd_data_o),
      .ready_o(ready_o), .cfg_o(cfg_o), .boost_adjust_o(boost_adjust_o));
   always #20 clk_i = ~clk_i;
   // Hang guard, well above the full run
   // Pulses are counted mid-cycle, where the output has settled
   always @(negedge clk_i) begin
      if (boost_adjust_o) pulses++;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(negedge clk_i) wr_i = '{1'b1, a, d};
      @(negedge clk_i) wr_i.we = 1'b0;
      repeat (2) @(negedge clk_i);
   endtask
   task automatic ticks(int s, int n);
      pulses = 0;
      repeat (32) begin
         @(negedge clk_i) adj = 1;
         @(negedge clk_i) adj = 0;
      end
      @(posedge clk_i);
      chk("adjust", 16'(n), 16'(pulses));
   endtask
   task automatic wrap_up;
      if (failures == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 0;
      wr(BBC_ADDR_DIM_CFG, 8'hFF);
      chk("early", 16'h0, 16'(ready_o));
      chk("ignored", 16'hF5, 16'(rd_data_o));
      valid = 1;
      repeat (3) @(negedge clk_i);
      chk("load", 16'h5A, 16'(rd_data_o));
      foreach (rows[i]) begin
         wr(BBC_ADDR_DIM_CFG, rows[i].d);
         chk("rate", 16'(rows[i].f), 16'(cfg_o.switch_rate));
         chk("dim", 16'(rows[i].d[5]), 16'(cfg_o.auto_dim));
         chk("temp", 16'(rows[i].t), 16'(cfg_o.derate_temp_c));
         chk("ramp", rows[i].r, cfg_o.ramp_ms);
         chk("read", 16'(rows[i].d), 16'(rd_data_o));
      end
      rd_addr_i = BBC_ADDR_BOOST_CFG;
      wr(BBC_ADDR_BOOST_CFG, 8'hD8);
      chk("boost", 16'h0007, {13'h0, cfg_o.light_load, cfg_o.split_25,
         cfg_o.headroom_tracking_enable});
      ticks(1, 2);
      wr(BBC_ADDR_BOOST_CFG, 8'h00);
      chk("rb", 16'h0000, 16'(rd_data_o));
      // A low clock enable must swallow a write
      @(negedge clk_i) ce_i = 0;
      wr(BBC_ADDR_BOOST_CFG, 8'hFF);
      ce_i = 1;
      repeat (2) @(negedge clk_i);
      chk("frozen", 16'h0000, 16'(rd_data_o));
      ticks(0, 32);
      @(negedge clk_i) rst_i = 1;
      @(negedge clk_i) chk("reset", 16'h0, 16'(ready_o));
      chk("rst_cfg", 16'h0, cfg_o.ramp_ms);
      rst_i = 0;
      @(negedge clk_i) chk("reload", 16'h0, 16'(ready_o));
      repeat (2) @(negedge clk_i);
      chk("ready", 16'h1, 16'(ready_o));
      chk("image", 16'h10, 16'(rd_data_o));
      wrap_up();
   end
endmodule
